// ---- hdl/lf_driver_spi_command_decoder.sv ----
// SPI command decoder, command FIFO and status logic of the LF driver
`timescale 1ns/1ps
`default_nettype none

module lf_driver_spi_command_decoder #(
    parameter int DEPTH = lf_cmd_pkg::FIFO_DEPTH,
    parameter int LOW_LEVEL = lf_cmd_pkg::FIFO_LOW
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    output logic irq,
    input wire logic supplies_ok,
    input wire logic overtemp,
    input wire logic [7:0] coil_line_state,
    input wire logic fault_valid,
    input wire logic [3:0] fault_type,
    output logic [7:0] mod_word,
    output logic mod_payload,
    output logic mod_valid,
    input wire logic mod_ready,
    input wire logic period_end,
    output logic driver_stop,
    output logic halt_pending,
    output logic diag_mode,
    output logic clock_polarity_cfg,
    output logic clock_phase_cfg
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || LOW_LEVEL >= DEPTH)
        begin : g_bad
            $error("DEPTH must be a power of two above LOW_LEVEL");
        end
    endgenerate

    // Input synchronisers
    logic [2:0] sck_ff, cs_ff;
    logic [1:0] mosi_ff, sup_ff, ot_ff;
    logic [7:0] line_meta_ff, line_ff;
    logic ot_d_ff;
    always_ff @(posedge sys_clk) begin
        sck_ff <= {sck_ff[1:0], spi_sck};
        cs_ff <= {cs_ff[1:0], spi_cs_n};
        mosi_ff <= {mosi_ff[0], spi_mosi};
        sup_ff <= {sup_ff[0], supplies_ok};
        ot_ff <= {ot_ff[0], overtemp};
        line_meta_ff <= coil_line_state;
        line_ff <= line_meta_ff;
        ot_d_ff <= ot_ff[1];
    end

    logic sck_rise, sck_fall, cs_fall, cs_act, ot_rise;
    assign sck_rise = sck_ff[1] && !sck_ff[2];
    assign sck_fall = !sck_ff[1] && sck_ff[2];
    assign cs_fall = !cs_ff[1] && cs_ff[2];
    assign cs_act = !cs_ff[1];
    assign ot_rise = ot_ff[1] && !ot_d_ff;

    // SPI engine
    logic cpol_ff, cpha_ff;
    logic samp_edge, shift_edge;
    logic [7:0] rx_ff, tx_ff;
    logic [2:0] bit_ff;
    logic first_ff, byte_done;
    logic [7:0] nxt_rx, resp;
    assign samp_edge = cs_act && ((cpol_ff == cpha_ff) ? sck_rise : sck_fall);
    assign shift_edge = cs_act && ((cpol_ff == cpha_ff) ? sck_fall : sck_rise);
    assign nxt_rx = {rx_ff[6:0], mosi_ff[1]};
    assign byte_done = samp_edge && (bit_ff == 3'(lf_cmd_pkg::SPI_BITS - 1));

    always_ff @(posedge sys_clk) begin
        if (rst || !cs_act) begin
            bit_ff <= 3'h0;
            rx_ff <= 8'h00;
        end else if (samp_edge) begin
            bit_ff <= bit_ff + 3'h1;
            rx_ff <= nxt_rx;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_ff <= 8'h00;
            first_ff <= 1'b0;
        end else if (cs_fall) begin
            tx_ff <= 8'h00;
            first_ff <= cpha_ff;
        end else if (byte_done) begin
            tx_ff <= resp;
            first_ff <= 1'b1;
        end else if (shift_edge) begin
            if (first_ff)
                first_ff <= 1'b0;
            else
                tx_ff <= {tx_ff[6:0], 1'b0};
        end
    end
    assign spi_miso = tx_ff[7];
    assign spi_miso_oe = cs_act;

    // Decode of a completed word
    logic [3:0] pay_left_ff;
    logic op_ok;
    logic is_status, is_setup, is_fault_rd, is_fault_rst, is_halt, is_cfg;
    logic is_drv, is_data, gen_cmd, push_req;
    lf_cmd_pkg::queue_word_t push_word;
    always_comb begin
        is_status = 1'b0;
        is_setup = 1'b0;
        is_fault_rd = 1'b0;
        is_fault_rst = 1'b0;
        is_halt = 1'b0;
        is_cfg = 1'b0;
        is_drv = 1'b0;
        is_data = 1'b0;
        if (byte_done && pay_left_ff == 4'h0) begin
            if (nxt_rx == lf_cmd_pkg::OP_STATUS_RD) begin
                is_status = 1'b1;
            end else if (nxt_rx == lf_cmd_pkg::OP_SETUP_RD) begin
                is_setup = 1'b1;
            end else if (nxt_rx == lf_cmd_pkg::OP_FAULT_RD) begin
                is_fault_rd = 1'b1;
            end else if (nxt_rx == lf_cmd_pkg::OP_FAULT_RST) begin
                is_fault_rst = 1'b1;
            end else if (nxt_rx == lf_cmd_pkg::OP_HALT) begin
                is_halt = 1'b1;
            end else if (nxt_rx[7:2] == lf_cmd_pkg::OP_SPI_CFG) begin
                is_cfg = 1'b1;
            end else if (nxt_rx[7:4] == lf_cmd_pkg::OP_LF_DATA) begin
                is_data = 1'b1;
                is_drv = 1'b1;
            end else if (nxt_rx[7:5] == lf_cmd_pkg::OP_SEL_DRV ||
                         nxt_rx[7:5] == lf_cmd_pkg::OP_SEL_CUR ||
                         nxt_rx[7:5] == lf_cmd_pkg::OP_CARRIER) begin
                is_drv = 1'b1;
            end
        end
    end
    assign gen_cmd = is_status || is_setup || is_fault_rd || is_fault_rst ||
                     is_halt || is_cfg;
    // Payload words follow their header; all are dropped while inoperable
    assign push_req = op_ok && (is_drv || (byte_done && pay_left_ff != 4'h0)
                      && !is_halt);
    assign push_word = '{payload: (pay_left_ff != 4'h0), data: nxt_rx};

    always_ff @(posedge sys_clk) begin
        if (rst || is_halt)
            pay_left_ff <= 4'h0;
        else if (is_data)
            pay_left_ff <= 4'(nxt_rx[lf_cmd_pkg::NIB_MSB:1]) + 4'h1;
        else if (byte_done && pay_left_ff != 4'h0)
            pay_left_ff <= pay_left_ff - 4'h1;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cpol_ff <= lf_cmd_pkg::CPOL_RST;
            cpha_ff <= lf_cmd_pkg::CPHA_RST;
        end else if (is_cfg) begin
            cpol_ff <= nxt_rx[lf_cmd_pkg::CFG_POL_BIT];
            cpha_ff <= nxt_rx[lf_cmd_pkg::CFG_PHA_BIT];
        end
    end
    assign clock_polarity_cfg = cpol_ff;
    assign clock_phase_cfg = cpha_ff;

    // Command FIFO
    lf_cmd_pkg::queue_word_t fifo_mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff, rd_ptr_ff;
    logic [CW-1:0] count_ff;
    logic fifo_full, fifo_pop, fifo_push, buf_in_ready;
    assign fifo_full = (count_ff == CW'(DEPTH));
    assign fifo_push = push_req && !fifo_full;
    assign fifo_pop = (count_ff != '0) && buf_in_ready;

    always_ff @(posedge sys_clk) begin
        if (fifo_push)
            fifo_mem[wr_ptr_ff] <= push_word;
    end

    always_ff @(posedge sys_clk) begin
        if (rst || is_halt) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (fifo_push)
                wr_ptr_ff <= wr_ptr_ff + AW'(1);
            if (fifo_pop)
                rd_ptr_ff <= rd_ptr_ff + AW'(1);
            if (fifo_push && !fifo_pop)
                count_ff <= count_ff + CW'(1);
            else if (fifo_pop && !fifo_push)
                count_ff <= count_ff - CW'(1);
        end
    end

    // Two-entry buffer towards the modulator
    lf_cmd_pkg::queue_word_t b0_ff, b1_ff;
    logic b0v_ff, b1v_ff, buf_out;
    assign buf_in_ready = !b1v_ff;
    assign buf_out = b0v_ff && mod_ready;
    always_ff @(posedge sys_clk) begin
        if (rst || is_halt) begin
            b0v_ff <= 1'b0;
            b1v_ff <= 1'b0;
        end else begin
            if (buf_out) begin
                b0_ff <= b1_ff;
                b0v_ff <= b1v_ff;
                b1v_ff <= 1'b0;
            end
            if (fifo_pop) begin
                if (!b0v_ff || buf_out) begin
                    b0_ff <= fifo_mem[rd_ptr_ff];
                    b0v_ff <= 1'b1;
                end else begin
                    b1_ff <= fifo_mem[rd_ptr_ff];
                    b1v_ff <= 1'b1;
                end
            end
        end
    end
    assign mod_word = b0_ff.data;
    assign mod_payload = b0_ff.payload;
    assign mod_valid = b0v_ff;

    // Driver setup, applied as commands reach the modulator in order
    logic [2:0] sel_ff;
    logic [4:0] step_ff;
    logic speed_ff, diag_ff, issue_cmd, diag_enter, diag_leave;
    assign issue_cmd = buf_out && !b0_ff.payload;
    assign diag_enter = issue_cmd && b0_ff.data[7:5] == lf_cmd_pkg::OP_SEL_DRV
                        && b0_ff.data[lf_cmd_pkg::DM_BIT];
    // Leaving diagnosis also needs a fault reset before operation resumes
    assign diag_leave = issue_cmd && b0_ff.data[7:5] == lf_cmd_pkg::OP_SEL_DRV
                        && !b0_ff.data[lf_cmd_pkg::DM_BIT] && diag_ff;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sel_ff <= lf_cmd_pkg::SEL_RST;
            step_ff <= lf_cmd_pkg::STEP_RST;
            speed_ff <= 1'b0;
            diag_ff <= 1'b0;
        end else if (issue_cmd) begin
            if (b0_ff.data[7:5] == lf_cmd_pkg::OP_SEL_DRV) begin
                speed_ff <= b0_ff.data[lf_cmd_pkg::BR_BIT];
                diag_ff <= b0_ff.data[lf_cmd_pkg::DM_BIT];
                sel_ff <= b0_ff.data[lf_cmd_pkg::SEL_MSB:0];
            end else if (b0_ff.data[7:5] == lf_cmd_pkg::OP_SEL_CUR) begin
                step_ff <= b0_ff.data[lf_cmd_pkg::STEP_MSB:0];
            end
        end
    end
    assign diag_mode = diag_ff;

    // Halt: stop request waits for the end of an LF period
    logic halt_ff;
    always_ff @(posedge sys_clk) begin
        if (rst)
            halt_ff <= 1'b0;
        else if (is_halt)
            halt_ff <= 1'b1;
        else if (period_end)
            halt_ff <= 1'b0;
    end
    assign driver_stop = halt_ff && period_end;
    assign halt_pending = halt_ff;

    // Fault register and operability
    lf_cmd_pkg::driver_fault_word_t fault_ff;
    logic op_ff;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fault_ff <= '0;
        end else if (fault_valid || ot_rise) begin
            fault_ff.sel <= sel_ff;
            fault_ff.overtemp <= fault_ff.overtemp || ot_rise;
            fault_ff.fault_type <= fault_ff.fault_type |
                                   (fault_valid ? fault_type : 4'h0);
        end else if (is_fault_rst) begin
            fault_ff <= '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst)
            op_ff <= 1'b0;
        else if (fault_valid || ot_rise || diag_enter || diag_leave)
            op_ff <= 1'b0;
        else if (is_fault_rst)
            op_ff <= sup_ff[1];
    end
    assign op_ok = op_ff && sup_ff[1] && fault_ff == '0;

    // Sticky status flags and interrupt request
    logic rflag_ff, boflag_ff, buflag_ff, irq_ff;
    logic low_event, ovf_event, any_event;
    assign low_event = fifo_pop && !fifo_push &&
                       count_ff == CW'(LOW_LEVEL + 1);
    assign ovf_event = push_req && fifo_full;
    assign any_event = low_event || ovf_event || fault_valid || ot_rise;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rflag_ff <= 1'b1;
            boflag_ff <= 1'b0;
            buflag_ff <= 1'b0;
            irq_ff <= 1'b1;
        end else begin
            rflag_ff <= rflag_ff && !is_status;
            boflag_ff <= ovf_event || (boflag_ff && !is_status);
            buflag_ff <= low_event || (buflag_ff && !is_status);
            irq_ff <= any_event || (irq_ff && !is_status);
        end
    end
    assign irq = irq_ff;

    // Answer words
    lf_cmd_pkg::ic_status_word_t status_w;
    lf_cmd_pkg::driver_setup_word_t setup_w;
    always_comb begin
        status_w = '{reset_flag: rflag_ff,
                     driver_fault_flag: fault_ff.fault_type != 4'h0,
                     buffer_overflow_flag: boflag_ff,
                     buffer_low_flag: buflag_ff,
                     overtemp_flag: fault_ff.overtemp,
                     speed_state: speed_ff,
                     operable_flag: op_ok,
                     unused: 1'b0};
        setup_w = {step_ff, sel_ff};
        resp = 8'h00;
        if (is_status)
            resp = status_w;
        else if (is_setup)
            resp = diag_ff ? line_ff : setup_w;
        else if (is_fault_rd)
            resp = fault_ff;
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_status_irq;
        is_status && !any_event |=> !irq;
    endproperty
    a_status_irq: assert property (p_status_irq)
        else $error("irq still high after status read");

    property p_halt_flush;
        is_halt |=> count_ff == '0 && !mod_valid ##1 !mod_valid;
    endproperty
    a_halt_flush: assert property (p_halt_flush)
        else $error("queue not emptied by halt");

    property p_stop_period;
        driver_stop |-> period_end && ($past(halt_ff) || $past(is_halt));
    endproperty
    a_stop_period: assert property (p_stop_period)
        else $error("driver stopped outside period end");

    property p_gate;
        fifo_push |-> op_ok && !gen_cmd;
    endproperty
    a_gate: assert property (p_gate)
        else $error("word queued while inoperable or general");

    logic buffer_low_seen;
    assign buffer_low_seen = buflag_ff && irq_ff && count_ff <= CW'(LOW_LEVEL);
    property p_low;
        low_event |=> buffer_low_seen;
    endproperty
    a_low: assert property (p_low)
        else $error("low flag missing at low fill");

    property p_ovf;
        push_req && fifo_full && !is_status |=> boflag_ff && irq_ff
            && count_ff <= $past(count_ff);
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow not flagged");

    property p_cfg;
        is_cfg |=> clock_polarity_cfg == $past(nxt_rx[1])
            && clock_phase_cfg == $past(nxt_rx[0]);
    endproperty
    a_cfg: assert property (p_cfg)
        else $error("configuration not loaded");

    property p_frst;
        is_fault_rst && !fault_valid && !ot_rise && !diag_enter && !diag_leave
            |=> fault_ff == '0
            && op_ff == $past(sup_ff[1]);
    endproperty
    a_frst: assert property (p_frst)
        else $error("fault reset did not clear");

    property p_answer;
        is_fault_rd |=> tx_ff == $past(fault_ff) ##1 tx_ff[7] == spi_miso;
    endproperty
    a_answer: assert property (p_answer)
        else $error("fault word not loaded for shifting");

    property p_select;
        issue_cmd && b0_ff.data[7:5] == lf_cmd_pkg::OP_SEL_DRV |=>
            sel_ff == $past(b0_ff.data[2:0]) && diag_mode == $past(b0_ff.data[3]);
    endproperty
    a_select: assert property (p_select)
        else $error("driver selection not applied");
endmodule

`default_nettype wire

// ---- hdl/lf_cmd_pkg.sv ----
// Constants and carrier types for the LF driver command decoder
package lf_cmd_pkg;
    // General commands, executed at once
    localparam logic [7:0] OP_STATUS_RD = 8'h60;
    localparam logic [7:0] OP_SETUP_RD = 8'h68;
    localparam logic [7:0] OP_FAULT_RD = 8'h70;
    localparam logic [7:0] OP_FAULT_RST = 8'h40;
    localparam logic [7:0] OP_HALT = 8'h50;
    localparam logic [5:0] OP_SPI_CFG = 6'h12;
    localparam int CFG_POL_BIT = 1;
    localparam int CFG_PHA_BIT = 0;
    // Driver-related commands, queued
    localparam logic [2:0] OP_SEL_DRV = 3'h1;
    localparam logic [2:0] OP_SEL_CUR = 3'h5;
    localparam logic [2:0] OP_CARRIER = 3'h4;
    localparam logic [3:0] OP_LF_DATA = 4'h0;
    // Field positions of driver-related command words
    localparam int BR_BIT = 4;
    localparam int DM_BIT = 3;
    localparam int SEL_MSB = 2;
    localparam int STEP_MSB = 4;
    localparam int NIB_MSB = 3;
    // Reset values, FIFO depth and low mark, SPI word length
    localparam logic [2:0] SEL_RST = 3'h1;
    localparam logic [4:0] STEP_RST = 5'h00;
    localparam logic CPOL_RST = 1'b1;
    localparam logic CPHA_RST = 1'b1;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_LOW = 4;
    localparam int SPI_BITS = 8;

    typedef struct packed {
        logic reset_flag;
        logic driver_fault_flag;
        logic buffer_overflow_flag;
        logic buffer_low_flag;
        logic overtemp_flag;
        logic speed_state;
        logic operable_flag;
        logic unused;
    } ic_status_word_t;

    typedef struct packed {
        logic [4:0] current_step;
        logic driver_group_select;
        logic [1:0] driver_index;
    } driver_setup_word_t;

    typedef struct packed {
        logic [2:0] sel;
        logic overtemp;
        logic [3:0] fault_type;
    } driver_fault_word_t;

    typedef struct packed {
        logic payload;
        logic [7:0] data;
    } queue_word_t;
endpackage

// ---- tb/spi_host_model.sv ----
// SPI master model standing in for the host controller
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
    output logic sck,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    logic cpol = 1'b1;
    logic cpha = 1'b1;

    initial begin
        sck = 1'b1;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // One frame of two words, MSB first; answer taken from the second
    task automatic xfer(input logic [7:0] b0, input logic [7:0] b1,
                        output logic [7:0] rsp);
        logic [15:0] tx;
        logic [15:0] rx;
        tx = {b0, b1};
        sck = cpol;
        #100 cs_n = 1'b0;
        #100;
        for (int i = 15; i >= 0; i--) begin
            if (!cpha) mosi = tx[i];
            #62.5 sck = ~cpol;
            if (cpha) mosi = tx[i];
            else rx[i] = miso;
            #62.5 sck = cpol;
            if (cpha) rx[i] = miso;
        end
        #100 cs_n = 1'b1;
        // Released line shows no stale data
        mosi = ~mosi;
        rsp = rx[7:0];
        #250;
    endtask
endmodule

`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the LF driver command decoder
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic supplies_ok = 1'b1;
    logic overtemp = 1'b0;
    logic [7:0] coil_line_state = 8'h00;
    logic fault_valid = 1'b0;
    logic [3:0] fault_type = 4'h0;
    logic mod_ready = 1'b0;
    logic period_end = 1'b0;
    logic spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, irq;
    logic mod_payload, mod_valid, driver_stop, halt_pending, diag_mode;
    logic cpol_out, cpha_out, drain;
    logic [7:0] mod_word, rsp, a, b;
    logic [8:0] head;
    logic [8:0] expq[$];
    integer seed = 25231;
    int err_count = 0;
    int samples_checked = 0;

    always #5 sys_clk = ~sys_clk;

    spi_host_model host (.sck(spi_sck), .cs_n(spi_cs_n), .mosi(spi_mosi),
        .miso(spi_miso));

    lf_driver_spi_command_decoder #(
        .DEPTH(lf_cmd_pkg::FIFO_DEPTH),
        .LOW_LEVEL(lf_cmd_pkg::FIFO_LOW)
    ) DUT (
        .sys_clk(sys_clk), .rst(rst), .spi_sck(spi_sck),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe), .irq(irq), .supplies_ok(supplies_ok),
        .overtemp(overtemp), .coil_line_state(coil_line_state),
        .fault_valid(fault_valid), .fault_type(fault_type),
        .mod_word(mod_word), .mod_payload(mod_payload),
        .mod_valid(mod_valid), .mod_ready(mod_ready),
        .period_end(period_end), .driver_stop(driver_stop),
        .halt_pending(halt_pending), .diag_mode(diag_mode),
        .clock_polarity_cfg(cpol_out), .clock_phase_cfg(cpha_out)
    );

    task automatic chk(input logic [8:0] got, input logic [8:0] exp,
                       input logic [8:0] mask);
        samples_checked++;
        if ((got & mask) !== (exp & mask)) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic flag(input logic got, input logic exp);
        chk({8'h00, got}, {8'h00, exp}, 9'h001);
    endtask

    task automatic cmd(input logic [7:0] b0, input logic [7:0] b1);
        host.xfer(b0, b1, rsp);
    endtask

    task automatic rd(input logic [7:0] op, input logic [8:0] exp,
                      input logic [8:0] mask);
        cmd(op, 8'hff);
        chk({1'b0, rsp}, exp, mask);
    endtask

    // Expected status word with the reset flag clear
    function automatic logic [8:0] st(input logic fl, ovf, lo, ot, spd, op);
        return {2'b00, fl, ovf, lo, ot, spd, op, 1'b0};
    endfunction

    task automatic wait_empty;
        for (int i = 0; i < 3000 && expq.size() != 0; i++) begin
            @(posedge sys_clk);
        end
        repeat (8) @(posedge sys_clk);
        flag(expq.size() == 0, 1'b1);
        flag(mod_valid, 1'b0);
    endtask

    task complete_run;
        $display("checked %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Modulator side with random stalls
    always @(posedge sys_clk) begin
        mod_ready <= drain & ($random(seed) % 3 != 0);
        if (mod_valid === 1'b1 && mod_ready === 1'b1) begin
            head = expq.size() != 0 ? expq.pop_front() : 'x;
            chk({mod_payload, mod_word}, head, 9'h1ff);
        end
    end

    initial begin
        #900000;
        err_count++;
        complete_run();
    end

    initial begin
        drain = 1'b0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        flag(irq, 1'b1);
        flag(spi_miso_oe, 1'b0);
        chk({7'h00, cpol_out, cpha_out}, 9'h003, 9'h003);
        rd(lf_cmd_pkg::OP_STATUS_RD, 9'h080, 9'h0fe);
        flag(irq, 1'b0);
        rd(lf_cmd_pkg::OP_SETUP_RD, 9'h001, 9'h0ff);
        cmd(8'h3d, 8'hff);
        repeat (20) @(posedge sys_clk);
        flag(mod_valid, 1'b0);
        cmd(lf_cmd_pkg::OP_FAULT_RST, 8'hff);
        rd(lf_cmd_pkg::OP_STATUS_RD, st(0, 0, 0, 0, 0, 1), 9'h0fe);
        for (int m = 0; m < 4; m++) begin
            cmd({lf_cmd_pkg::OP_SPI_CFG, m[1:0]}, 8'hff);
            host.cpol = m[1];
            host.cpha = m[0];
            chk({7'h00, cpol_out, cpha_out}, 9'(m), 9'h003);
            rd(lf_cmd_pkg::OP_SETUP_RD, 9'h001, 9'h0ff);
        end
        // Queued commands with a halt opcode hidden as payload
        expq = '{9'h035, 9'h0b3, 9'h001, 9'h150, 9'h080};
        cmd(8'h35, 8'hb3);
        cmd(8'h01, 8'h50);
        cmd(8'h80, 8'hff);
        flag(halt_pending, 1'b0);
        drain = 1'b1;
        wait_empty();
        rd(lf_cmd_pkg::OP_SETUP_RD, {1'b0, 5'd19, 3'b101}, 9'h0ff);
        rd(lf_cmd_pkg::OP_STATUS_RD, st(0, 0, 0, 0, 1, 1), 9'h0ee);
        // Overfill the queue, then drain it past the low mark
        drain = 1'b0;
        for (int i = 0; i < 10; i++) begin
            a = {3'b101, 5'($unsigned($random(seed)) % 20)};
            b = {3'b101, 5'($unsigned($random(seed)) % 20)};
            if (i < 9) begin
                expq.push_back({1'b0, a});
                expq.push_back({1'b0, b});
            end
            cmd(a, b);
        end
        flag(irq, 1'b1);
        rd(lf_cmd_pkg::OP_STATUS_RD, st(0, 1, 0, 0, 1, 1), 9'h0ee);
        drain = 1'b1;
        wait_empty();
        rd(lf_cmd_pkg::OP_STATUS_RD, st(0, 0, 1, 0, 1, 1), 9'h0fe);
        // Halt with words still queued
        drain = 1'b0;
        cmd(8'ha1, 8'ha2);
        cmd(lf_cmd_pkg::OP_HALT, 8'hff);
        flag(halt_pending, 1'b1);
        drain = 1'b1;
        wait_empty();
        @(negedge sys_clk);
        flag(driver_stop, 1'b0);
        @(posedge sys_clk);
        period_end <= 1'b1;
        @(negedge sys_clk);
        flag(driver_stop, 1'b1);
        @(posedge sys_clk);
        period_end <= 1'b0;
        @(negedge sys_clk);
        flag(halt_pending, 1'b0);
        // Driver fault and overtemperature together
        @(posedge sys_clk);
        fault_valid <= 1'b1;
        fault_type <= 4'ha;
        overtemp <= 1'b1;
        @(posedge sys_clk);
        fault_valid <= 1'b0;
        repeat (4) @(posedge sys_clk);
        flag(irq, 1'b1);
        rd(lf_cmd_pkg::OP_FAULT_RD, 9'h0ba, 9'h0ff);
        rd(lf_cmd_pkg::OP_STATUS_RD, st(1, 0, 0, 1, 1, 0), 9'h0ee);
        cmd(8'ha0, 8'hff);
        wait_empty();
        overtemp <= 1'b0;
        cmd(lf_cmd_pkg::OP_FAULT_RST, 8'hff);
        rd(lf_cmd_pkg::OP_FAULT_RD, 9'h000, 9'h01f);
        rd(lf_cmd_pkg::OP_STATUS_RD, st(0, 0, 0, 0, 1, 1), 9'h0ee);
        // Diagnosis entry and exit
        @(posedge sys_clk);
        coil_line_state <= 8'($random(seed));
        expq.push_back(9'h029);
        cmd(8'h29, 8'hff);
        wait_empty();
        flag(diag_mode, 1'b1);
        rd(lf_cmd_pkg::OP_SETUP_RD, {1'b0, coil_line_state}, 9'h0ff);
        cmd(lf_cmd_pkg::OP_FAULT_RST, 8'hff);
        expq.push_back(9'h021);
        cmd(8'h21, 8'hff);
        wait_empty();
        flag(diag_mode, 1'b0);
        rd(lf_cmd_pkg::OP_STATUS_RD, st(0, 0, 0, 0, 0, 0), 9'h0ee);
        cmd(lf_cmd_pkg::OP_FAULT_RST, 8'hff);
        rd(lf_cmd_pkg::OP_STATUS_RD, st(0, 0, 0, 0, 0, 1), 9'h0ee);
        complete_run();
    end
endmodule

`default_nettype wire
